// ---- verilog/crrp_core_end.sv ----
// Overview of operation
// - Coprocessor data valid only with data strobe
// - Condition strobe marks valid condition result
// - Strobe with high result takes branch
// - Strobe with low result skips branch
// - Exception strobe only with valid flag, cause
// - Core samples exception flag under strobe
// - Cause decoded only with strobe and flag
// - Cause 01010 means reserved instruction
// - Causes 10000, 10001 are coprocessor specific
`timescale 1ns/1ns
module crrp_core_end
(
  input  wire logic        clk_sys,          // Core clock
  input  wire logic        rst_b,            // Async reset, active low
  crrp_if.core             link,             // Return path from coprocessor
  output logic [31:0]      data_word,        // Captured coprocessor data
  output logic             data_valid,       // Pulse: data_word is new
  output logic             branch_resolved,  // Pulse: branch outcome known
  output logic             branch_taken,     // Outcome of the resolved branch
  output logic             exc_valid,        // Pulse: exception status reported
  output logic             exc_raise,        // Pulse: exception raised
  output logic             exc_reserved,     // Pulse: reserved-instruction exception
  output logic             exc_impl,         // Pulse: coprocessor-specific exception
  output logic [4:0]       exc_cause         // Cause of the raised exception
);
  // Data capture: next values
  logic [31:0] next_data_word;
  logic        next_data_valid;

  // Branch outcome: next values
  logic        next_branch_resolved;
  logic        next_branch_taken;

  // Exception status: next values
  logic        next_exc_valid;
  logic        next_exc_raise;
  logic [4:0]  next_exc_cause;

  // Exception class: next values
  logic        next_exc_reserved;
  logic        next_exc_impl;

  // Classify a cause code
  function automatic crrp_pkg::crrp_exc_kind_t classify(input logic [4:0] c);
    if (c == crrp_pkg::CAUSE_RESERVED_INSTR)
      return crrp_pkg::CRRP_EXC_RESERVED;
    else if (c == crrp_pkg::CAUSE_IMPL_SPEC_0 || c == crrp_pkg::CAUSE_IMPL_SPEC_1)
      return crrp_pkg::CRRP_EXC_IMPL;
    else
      return crrp_pkg::CRRP_EXC_OTHER;
  endfunction

  // A cause counts only under both strobe and flag
  function automatic logic exc_raised(input logic stb, input logic flag);
    return stb & flag;
  endfunction

  // Data capture: take the word only under its strobe
  always_comb
  begin
    // Defaults: pulse low, word held
    next_data_word  = data_word;
    next_data_valid = 1'h0;
    if (link.from_cop_data_strobe)
    begin
      next_data_word  = link.from_cop_data;
      next_data_valid = 1'h1;
    end
  end

  // Data capture registers
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Reset values
      data_word  <= crrp_pkg::RST_DATA_WORD;
      data_valid <= crrp_pkg::RST_FLAG;
    end
    else
    begin
      // Registered updates
      data_word  <= next_data_word;
      data_valid <= next_data_valid;
    end
  end

  // Branch outcome: resolve only under the condition strobe
  always_comb
  begin
    // Defaults: pulse low, outcome held
    next_branch_resolved = 1'h0;
    next_branch_taken    = branch_taken;
    if (link.cond_check_strobe)
    begin
      next_branch_resolved = 1'h1;
      next_branch_taken    = link.cond_check_result;
    end
  end

  // Branch outcome registers
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Reset values
      branch_resolved <= crrp_pkg::RST_FLAG;
      branch_taken    <= crrp_pkg::RST_FLAG;
    end
    else
    begin
      // Registered updates
      branch_resolved <= next_branch_resolved;
      branch_taken    <= next_branch_taken;
    end
  end

  // Exception status: pulse whenever a report arrives
  always_comb
  begin
    // Default: no report
    next_exc_valid = 1'h0;
    if (link.cop_exception_strobe)
    begin
      next_exc_valid = 1'h1;
    end
  end

  // Exception status register
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Reset value
      exc_valid <= crrp_pkg::RST_FLAG;
    end
    else
    begin
      // Registered update
      exc_valid <= next_exc_valid;
    end
  end

  // Exception raise: the cause is kept from the last raised exception
  always_comb
  begin
    // Defaults: pulse low, cause held
    next_exc_raise = 1'h0;
    next_exc_cause = exc_cause;
    if (exc_raised(link.cop_exception_strobe, link.cop_exception_flag))
    begin
      next_exc_raise = 1'h1;
      next_exc_cause = link.cop_exception_cause;
    end
  end

  // Exception raise registers
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Reset values
      exc_raise <= crrp_pkg::RST_FLAG;
      exc_cause <= crrp_pkg::RST_CAUSE;
    end
    else
    begin
      // Registered updates
      exc_raise <= next_exc_raise;
      exc_cause <= next_exc_cause;
    end
  end

  // Exception class: decode the cause of a raised exception only
  always_comb
  begin
    crrp_pkg::crrp_exc_kind_t kind;
    // Default: nothing raised
    kind = crrp_pkg::CRRP_EXC_NONE;
    if (exc_raised(link.cop_exception_strobe, link.cop_exception_flag))
    begin
      kind = classify(link.cop_exception_cause);
    end
    next_exc_reserved = (kind == crrp_pkg::CRRP_EXC_RESERVED);
    next_exc_impl     = (kind == crrp_pkg::CRRP_EXC_IMPL);
  end

  // Exception class registers
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Reset values
      exc_reserved <= crrp_pkg::RST_FLAG;
      exc_impl     <= crrp_pkg::RST_FLAG;
    end
    else
    begin
      // Registered updates
      exc_reserved <= next_exc_reserved;
      exc_impl     <= next_exc_impl;
    end
  end
endmodule

// ---- verilog/crrp_pkg.sv ----
package crrp_pkg;
  // Link widths
  localparam int DATA_W  = 32;
  localparam int CAUSE_W = 5;
  // Exception cause encodings
  localparam logic [4:0] CAUSE_RESERVED_INSTR = 5'h0a;
  localparam logic [4:0] CAUSE_IMPL_SPEC_0    = 5'h10;
  localparam logic [4:0] CAUSE_IMPL_SPEC_1    = 5'h11;
  // Reset values of the registered link and outputs
  localparam logic [31:0] RST_DATA_WORD = 32'h0000_0000;
  localparam logic [4:0]  RST_CAUSE     = 5'h00;
  localparam logic        RST_FLAG      = 1'h0;
  // Core-side classification of a reported exception
  typedef enum logic [1:0] {
    CRRP_EXC_NONE,
    CRRP_EXC_RESERVED,
    CRRP_EXC_IMPL,
    CRRP_EXC_OTHER
  } crrp_exc_kind_t;
endpackage

// ---- verilog/crrp_if.sv ----
`timescale 1ns/1ns
interface crrp_if;
  logic [31:0] from_cop_data;
  logic        from_cop_data_strobe;
  logic        cond_check_strobe;
  logic        cond_check_result;
  logic        cop_exception_strobe;
  logic        cop_exception_flag;
  logic [4:0]  cop_exception_cause;

  modport core
  (
    input from_cop_data, from_cop_data_strobe, cond_check_strobe, cond_check_result,
    input cop_exception_strobe, cop_exception_flag, cop_exception_cause
  );
  modport cop
  (
    output from_cop_data, from_cop_data_strobe, cond_check_strobe, cond_check_result,
    output cop_exception_strobe, cop_exception_flag, cop_exception_cause
  );
endinterface

// ---- verilog/crrp_cop_end.sv ----
`timescale 1ns/1ns
module crrp_cop_end
(
  input  wire logic        clk_sys,       // Core clock
  input  wire logic        rst_b,         // Async reset, active low
  input  wire logic        data_req,      // Pulse: send data word
  input  wire logic [31:0] data_in,       // Data word to send
  input  wire logic        cond_req,      // Pulse: send condition result
  input  wire logic        cond_in,       // Condition result to send
  input  wire logic        exc_req,       // Pulse: send exception status
  input  wire logic        exc_in,        // Exception raised
  input  wire logic        unimpl_in,     // Opcode not implemented
  input  wire logic [4:0]  cause_in,      // Cause when implemented
  crrp_if.cop              link           // Return path toward core
);
  logic [31:0] data_q;
  logic        data_stb_q;
  logic        cond_stb_q;
  logic        cond_q;
  logic        exc_stb_q;
  logic        exc_flag_q;
  logic [4:0]  cause_q;
  logic [31:0] next_data_q;
  logic        next_data_stb_q;
  logic        next_cond_stb_q;
  logic        next_cond_q;
  logic        next_exc_stb_q;
  logic        next_exc_flag_q;
  logic [4:0]  next_cause_q;

  // One-cycle strobes with qualified payload, in request order
  always_comb
  begin
    next_data_q     = data_q;
    next_data_stb_q = data_req;
    next_cond_stb_q = cond_req;
    next_cond_q     = cond_q;
    next_exc_stb_q  = exc_req;
    next_exc_flag_q = exc_flag_q;
    next_cause_q    = cause_q;
    if (data_req)
      next_data_q = data_in;
    if (cond_req)
      next_cond_q = cond_in;
    if (exc_req)
    begin
      next_exc_flag_q = exc_in | unimpl_in;
      next_cause_q    = unimpl_in ? crrp_pkg::CAUSE_RESERVED_INSTR : cause_in;
    end
  end

  // Register link outputs
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      data_q     <= crrp_pkg::RST_DATA_WORD;
      data_stb_q <= crrp_pkg::RST_FLAG;
      cond_stb_q <= crrp_pkg::RST_FLAG;
      cond_q     <= crrp_pkg::RST_FLAG;
      exc_stb_q  <= crrp_pkg::RST_FLAG;
      exc_flag_q <= crrp_pkg::RST_FLAG;
      cause_q    <= crrp_pkg::RST_CAUSE;
    end
    else
    begin
      data_q     <= next_data_q;
      data_stb_q <= next_data_stb_q;
      cond_stb_q <= next_cond_stb_q;
      cond_q     <= next_cond_q;
      exc_stb_q  <= next_exc_stb_q;
      exc_flag_q <= next_exc_flag_q;
      cause_q    <= next_cause_q;
    end
  end

  // Drive the link
  assign link.from_cop_data        = data_q;
  assign link.from_cop_data_strobe = data_stb_q;
  assign link.cond_check_strobe    = cond_stb_q;
  assign link.cond_check_result    = cond_q;
  assign link.cop_exception_strobe = exc_stb_q;
  assign link.cop_exception_flag   = exc_flag_q;
  assign link.cop_exception_cause  = cause_q;
endmodule

// ---- bench/crrp_properties.sv ----
`timescale 1ns/1ns
module crrp_properties
(
  input wire logic        clk_sys,              // Clock
  input wire logic        rst_b,                // Reset, active low
  input wire logic [31:0] from_cop_data,        // Link
  input wire logic        from_cop_data_strobe, // Link
  input wire logic        cond_check_strobe,    // Link
  input wire logic        cond_check_result,    // Link
  input wire logic        cop_exception_strobe, // Link
  input wire logic        cop_exception_flag,   // Link
  input wire logic [4:0]  cop_exception_cause,  // Link
  input wire logic [31:0] data_word,            // Core
  input wire logic        data_valid,           // Core
  input wire logic        branch_resolved,      // Core
  input wire logic        branch_taken,         // Core
  input wire logic        exc_valid,            // Core
  input wire logic        exc_raise,            // Core
  input wire logic        exc_reserved,         // Core
  input wire logic        exc_impl,             // Core
  input wire logic [4:0]  exc_cause             // Core
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire raise_in = cop_exception_strobe && cop_exception_flag;
  // Core reaction one cycle after each link strobe
  property p_dat; from_cop_data_strobe |=> data_valid; endproperty
  a_dat: assert property (p_dat) else $error("no data pulse");
  property p_take; cond_check_strobe && cond_check_result |=> branch_resolved && branch_taken;
  endproperty
  a_take: assert property (p_take) else $error("branch not taken");
  property p_skip; cond_check_strobe && !cond_check_result |=> branch_resolved && !branch_taken;
  endproperty
  a_skip: assert property (p_skip) else $error("branch taken");
  property p_raise; raise_in |=> exc_raise; endproperty
  a_raise: assert property (p_raise) else $error("no raise");
  property p_quiet; !raise_in |=> !exc_raise; endproperty
  a_quiet: assert property (p_quiet) else $error("stray raise");
  property p_code; raise_in |=> exc_cause == $past(cop_exception_cause); endproperty
  a_code: assert property (p_code) else $error("bad cause");
  property p_keep; !raise_in |=> $stable(exc_cause); endproperty
  a_keep: assert property (p_keep) else $error("cause moved");
  // Class pulses follow the reported cause
  property p_ri; exc_raise |-> exc_reserved == (exc_cause == 5'h0a); endproperty
  a_ri: assert property (p_ri) else $error("bad reserved class");
  property p_is; exc_raise |-> exc_impl == (exc_cause[4:1] == 4'h8); endproperty
  a_is: assert property (p_is) else $error("bad specific class");
  // Nothing moves without its strobe
  property p_word; from_cop_data_strobe |=> data_word == $past(from_cop_data); endproperty
  a_word: assert property (p_word) else $error("data word not taken");
  property p_hold; !from_cop_data_strobe |=> $stable(data_word) && !data_valid; endproperty
  a_hold: assert property (p_hold) else $error("data moved without strobe");
  property p_nobr; !cond_check_strobe |=> !branch_resolved && $stable(branch_taken); endproperty
  a_nobr: assert property (p_nobr) else $error("branch moved without strobe");
  property p_exv; cop_exception_strobe |=> exc_valid; endproperty
  a_exv: assert property (p_exv) else $error("no status pulse");
  property p_exq; !cop_exception_strobe |=> !exc_valid; endproperty
  a_exq: assert property (p_exq) else $error("stray status pulse");
  property p_cls; !exc_raise |-> !exc_reserved && !exc_impl; endproperty
  a_cls: assert property (p_cls) else $error("class without raise");
  c_ri: cover property (exc_reserved);
  c_is: cover property (exc_impl);
  c_br: cover property (branch_resolved && branch_taken);
  c_st: cover property (exc_valid && !exc_raise);
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ns
module tb;
  logic        clk_sys = 0;
  logic        rst_b = 0;
  logic        data_req = 0, cond_req = 0, cond_in = 0, exc_req = 0, exc_in = 0, unimpl_in = 0;
  logic [31:0] data_in = '0, data_word;
  logic [4:0]  cause_in = '0, exc_cause;
  logic        data_valid, branch_resolved, branch_taken, exc_valid, exc_raise, exc_reserved;
  logic        exc_impl;
  int          fail_count = 0;
  int          n_compared = 0;
  crrp_if link ();
  crrp_cop_end crrp_cop_end_inst (.clk_sys, .rst_b, .data_req, .data_in, .cond_req, .cond_in,
    .exc_req, .exc_in, .unimpl_in, .cause_in, .link(link));
  crrp_core_end crrp_core_end_inst (.clk_sys, .rst_b, .link(link), .data_word, .data_valid,
    .branch_resolved, .branch_taken, .exc_valid, .exc_raise, .exc_reserved, .exc_impl, .exc_cause);
  crrp_properties crrp_properties_inst (.clk_sys, .rst_b, .from_cop_data(link.from_cop_data),
    .from_cop_data_strobe(link.from_cop_data_strobe), .cond_check_strobe(link.cond_check_strobe),
    .cond_check_result(link.cond_check_result), .cop_exception_strobe(link.cop_exception_strobe),
    .cop_exception_flag(link.cop_exception_flag), .cop_exception_cause(link.cop_exception_cause),
    .data_word, .data_valid, .branch_resolved, .branch_taken, .exc_valid, .exc_raise,
    .exc_reserved, .exc_impl, .exc_cause);
  // Clock
  always #5 clk_sys = ~clk_sys;
  // Compare and count
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // Release requests, then stop inside the core's one-cycle pulse
  task automatic fire();
    @(negedge clk_sys);
    {data_req, cond_req, exc_req} = '0;
    @(negedge clk_sys);
  endtask
  // One exception report with its expected core view
  task automatic exc(input logic f, u, input logic [4:0] c, ec, input logic r, i);
    {exc_in, unimpl_in, cause_in, exc_req} = {f, u, c, 1'b1};
    fire();
    chk("exc_valid", exc_valid, 1);
    chk("exc_raise", exc_raise, f | u);
    chk("exc_reserved", exc_reserved, r);
    chk("exc_impl", exc_impl, i);
    chk("exc_cause", exc_cause, ec);
    @(negedge clk_sys);
    chk("exc_valid_end", exc_valid, 0);
  endtask
  // Verdict
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(negedge clk_sys);
    rst_b = 1;
    for (int j = 0; j < 2; j++)
    begin
      {data_in, data_req} = {j ? 32'h5a3c_96e1 : 32'hffff_ffff, 1'h1};
      fire();
      chk("data_valid", data_valid, 1);
      chk("data_word", data_word, j ? 32'h5a3c_96e1 : 32'hffff_ffff);
    end
    // Reset in mid-run clears the held word
    rst_b = 0;
    @(negedge clk_sys);
    chk("data_word_rst", data_word, crrp_pkg::RST_DATA_WORD);
    rst_b = 1;
    for (int k = 1; k >= 0; k--)
    begin
      {cond_in, cond_req} = {k[0], 1'h1};
      fire();
      chk("branch_resolved", branch_resolved, 1);
      chk("branch_taken", branch_taken, k);
    end
    exc(0, 0, 5'h0a, 5'h00, 0, 0);
    exc(0, 1, 5'h1f, 5'h0a, 1, 0);
    exc(1, 0, 5'h10, 5'h10, 0, 1);
    exc(1, 0, 5'h11, 5'h11, 0, 1);
    exc(1, 0, 5'h05, 5'h05, 0, 0);
    exc(1, 0, 5'h0a, 5'h0a, 1, 0);
    end_sim();
  end
endmodule
